/* include/amd_pkg.sv */
// Package for the addressing mode decoder
package amd_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_ADDR = 16'h0000;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_TWO = 3'h2;
	localparam logic [2:0] LEN_THREE = 3'h3;
	localparam int unsigned NUM_MODES = 8;
	localparam int unsigned NUM_INSTR = 62;

	typedef enum logic [2:0] {
		AMD_INH = 3'h0,
		AMD_IMM = 3'h1,
		AMD_DIR = 3'h2,
		AMD_EXT = 3'h3,
		AMD_IX  = 3'h4,
		AMD_IX1 = 3'h5,
		AMD_IX2 = 3'h6,
		AMD_REL = 3'h7
	} amd_mode_t;

	typedef enum logic [2:0] {
		AMD_CLS_REGMEM = 3'h0,
		AMD_CLS_RMW    = 3'h1,
		AMD_CLS_JMPBR  = 3'h2,
		AMD_CLS_BIT    = 3'h3,
		AMD_CLS_CTRL   = 3'h4
	} amd_class_t;

	// Fetch state: Gray order along the byte stream
	typedef enum logic [1:0] {
		AMD_ST_OPC  = 2'b00,
		AMD_ST_BYT1 = 2'b01,
		AMD_ST_BYT2 = 2'b11
	} amd_state_t;

	typedef struct packed {
		logic        valid;
		amd_mode_t   mode;
		amd_class_t  cls;
		logic        useIndex;
		logic        isMultiply;
		logic        branchTaken;
	} amd_instr_t;

	typedef struct packed {
		logic [7:0]  accA;
		logic [7:0]  idxX;
		logic [15:0] pc;
	} amd_regs_t;

	typedef struct packed {
		logic        done;
		logic [2:0]  length;
		logic        eaValid;
		logic [15:0] effAddr;
		logic [7:0]  operand;
		logic        opFromMem;
		logic        regSelX;
		logic [15:0] nextPc;
		logic        mulValid;
		logic [7:0]  mulHi;
		logic [7:0]  mulLo;
	} amd_result_t;

	typedef struct packed {
		amd_state_t  state;
		amd_instr_t  instr;
		amd_regs_t   regs;
		logic [7:0]  byte1;
		amd_result_t res;
	} amd_state_all_t;
endpackage

/* src/amd_decoder.sv */
// Addressing mode decoder and effective address generator
// Function
// - Multiply A by X unsigned; high byte to X, low byte to A.
// - Inherent instructions are one byte with no operand address.
// - Immediate instructions are two bytes; second byte is the literal.
// - Direct is two bytes; address high byte zero, low from second byte.
// - Extended is three bytes; high then low address byte.
// - Indexed no offset is one byte; address is X, high byte zero.
// - Indexed 8-bit offset is two bytes; address is X plus byte.
// - Indexed 16-bit offset is three bytes; X plus offset, high first.
// - Taken branch goes to next address plus sign-extended offset byte.
// - Untaken branch continues with the next instruction.
// - Register/memory takes A or X and a memory operand at the address.
// - Eight addressing modes, 62 instructions in five classes.
`timescale 1ns/100ps
module amd_decoder
	import amd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        opValid,
	input  wire amd_instr_t  opInfo,
	input  wire amd_regs_t   regsIn,
	input  wire logic        fetchValid,
	input  wire logic [7:0]  fetchByte,
	output logic             fetchReady,
	output amd_result_t      result
);

	amd_state_all_t stFf;
	amd_state_all_t nxtSt;

	// Number of bytes following the opcode
	// all eight modes decoded
	function automatic logic [1:0] extraBytes(input amd_mode_t m);
		unique case (m)
			AMD_INH, AMD_IX:          extraBytes = 2'd0;
			AMD_IMM, AMD_DIR,
			AMD_IX1, AMD_REL:         extraBytes = 2'd1;
			AMD_EXT, AMD_IX2:         extraBytes = 2'd2;
		endcase
	endfunction

	// Instruction length in bytes
	function automatic logic [2:0] instrLen(input amd_mode_t m);
		instrLen = {1'b0, extraBytes(m)} + LEN_ONE;
	endfunction

	// Memory operand needed by the mode
	function automatic logic memOperand(input amd_mode_t m);
		memOperand = (m == AMD_DIR) || (m == AMD_EXT) || (m == AMD_IX)
			|| (m == AMD_IX1) || (m == AMD_IX2);
	endfunction

	logic [15:0] pcAfter;
	logic [15:0] eaCalc;
	logic [15:0] relTarget;
	logic [7:0]  lastByte;

	assign fetchReady = (stFf.state != AMD_ST_OPC);

	always_comb
	begin
		nxtSt = stFf;
		nxtSt.res.done = 1'b0;
		nxtSt.res.mulValid = 1'b0;
		lastByte = fetchByte;
		pcAfter = stFf.regs.pc + {13'h0000, instrLen(stFf.instr.mode)};
		relTarget = pcAfter + {{8{lastByte[7]}}, lastByte};
		eaCalc = RESET_ADDR;
		unique case (stFf.instr.mode)
			AMD_DIR: eaCalc = {ZERO_PAGE_HI, lastByte};
			AMD_EXT: eaCalc = {stFf.byte1, lastByte};
			AMD_IX:  eaCalc = {ZERO_PAGE_HI, stFf.regs.idxX};
			AMD_IX1: eaCalc = {7'h00,
				9'({1'b0, stFf.regs.idxX} + {1'b0, lastByte})};
			AMD_IX2: eaCalc = 16'({stFf.byte1, lastByte}
				+ {8'h00, stFf.regs.idxX});
			AMD_INH, AMD_IMM, AMD_REL: eaCalc = RESET_ADDR;
		endcase

		unique case (stFf.state)
			AMD_ST_OPC:
			begin
				if (opValid)
				begin
					nxtSt.instr = opInfo;
					nxtSt.regs = regsIn;
					if (extraBytes(opInfo.mode) == 2'd0)
					begin
						nxtSt.state = AMD_ST_OPC;
					end
					else
					begin
						nxtSt.state = AMD_ST_BYT1;
					end
				end
			end
			AMD_ST_BYT1:
			begin
				if (fetchValid)
				begin
					nxtSt.byte1 = fetchByte;
					if (extraBytes(stFf.instr.mode) == 2'd2)
					begin
						nxtSt.state = AMD_ST_BYT2;
					end
					else
					begin
						nxtSt.state = AMD_ST_OPC;
					end
				end
			end
			AMD_ST_BYT2:
			begin
				if (fetchValid)
				begin
					nxtSt.state = AMD_ST_OPC;
				end
			end
			default:
			begin
				nxtSt.state = AMD_ST_OPC;
			end
		endcase
	end

	// Completion of a decode, computed from the current state
	logic finish;
	logic oneByte;
	always_comb
	begin
		oneByte = (stFf.state == AMD_ST_OPC) && opValid
			&& (extraBytes(opInfo.mode) == 2'd0);
		finish = ((stFf.state == AMD_ST_BYT1) && fetchValid
			&& (extraBytes(stFf.instr.mode) == 2'd1))
			|| ((stFf.state == AMD_ST_BYT2) && fetchValid);
	end

	amd_result_t resNxt;
	logic [15:0] pcOne;
	logic [15:0] mulOne;
	logic [15:0] eaOne;
	always_comb
	begin
		resNxt = '0;
		pcOne = regsIn.pc + {13'h0000, LEN_ONE};
		mulOne = regsIn.accA * regsIn.idxX;
		eaOne = {ZERO_PAGE_HI, regsIn.idxX};
		if (oneByte)
		begin
			resNxt.done = 1'b1;
			resNxt.length = LEN_ONE;
			resNxt.nextPc = pcOne;
			resNxt.regSelX = opInfo.useIndex;
			resNxt.eaValid = (opInfo.mode == AMD_IX);
			resNxt.effAddr = (opInfo.mode == AMD_IX) ? eaOne : RESET_ADDR;
			resNxt.opFromMem = (opInfo.mode == AMD_IX)
				&& (opInfo.cls == AMD_CLS_REGMEM);
			// high to X, low to A
			resNxt.mulValid = opInfo.isMultiply;
			resNxt.mulHi = mulOne[15:8];
			resNxt.mulLo = mulOne[7:0];
		end
		else if (finish)
		begin
			resNxt.done = 1'b1;
			resNxt.length = instrLen(stFf.instr.mode);
			resNxt.regSelX = stFf.instr.useIndex;
			resNxt.eaValid = memOperand(stFf.instr.mode);
			resNxt.effAddr = eaCalc;
			resNxt.opFromMem = memOperand(stFf.instr.mode)
				&& (stFf.instr.cls == AMD_CLS_REGMEM);
			resNxt.operand = (stFf.instr.mode == AMD_IMM)
				? lastByte : RESET_BYTE;
			if ((stFf.instr.mode == AMD_REL) && stFf.instr.branchTaken)
			begin
				resNxt.nextPc = relTarget;
			end
			else
			begin
				resNxt.nextPc = pcAfter;
			end
		end
		else
		begin
			resNxt = stFf.res;
			resNxt.done = 1'b0;
			resNxt.mulValid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stFf <= '0;
		end
		else
		begin
			stFf <= {nxtSt.state, nxtSt.instr, nxtSt.regs, nxtSt.byte1,
				resNxt};
		end
	end

	assign result = stFf.res;

	// inherent finishes in one cycle with no address
	inh_one_cyc_a: assert property (@(posedge clk) disable iff (!arst_n)
		(stFf.state == AMD_ST_OPC && opValid && opInfo.mode == AMD_INH)
		|=> (result.done && !result.eaValid && result.length == 3'd1))
		else $error("inherent decode wrong");

	imm_literal_a: assert property (@(posedge clk) disable iff (!arst_n)
		(stFf.state == AMD_ST_BYT1 && fetchValid
		&& stFf.instr.mode == AMD_IMM)
		|=> (result.done && result.operand == $past(fetchByte)
		&& result.length == 3'd2))
		else $error("immediate operand wrong");

	dir_zero_page_a: assert property (@(posedge clk) disable iff (!arst_n)
		(stFf.state == AMD_ST_BYT1 && fetchValid
		&& stFf.instr.mode == AMD_DIR)
		|=> (result.effAddr == {8'h00, $past(fetchByte)}))
		else $error("direct address wrong");

	sequence extSeq;
		stFf.state == AMD_ST_BYT1 && fetchValid
		&& stFf.instr.mode == AMD_EXT;
	endsequence
	ext_three_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
		extSeq |=> !result.done)
		else $error("extended ended early");

	ix_zero_off_a: assert property (@(posedge clk) disable iff (!arst_n)
		(oneByte && opInfo.mode == AMD_IX)
		|=> (result.effAddr == {8'h00, $past(regsIn.idxX)}))
		else $error("indexed address wrong");

	ix1_range_a: assert property (@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.mode == AMD_IX1)
		|=> (result.effAddr <= 16'h01FE))
		else $error("indexed 8-bit range wrong");

	ix2_sum_a: assert property (@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.mode == AMD_IX2)
		|=> (result.effAddr == 16'({$past(stFf.byte1), $past(fetchByte)}
		+ {8'h00, $past(stFf.regs.idxX)})))
		else $error("indexed 16-bit sum wrong");

	br_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.mode == AMD_REL && !stFf.instr.branchTaken)
		|=> (result.nextPc == $past(stFf.regs.pc) + 16'h0002))
		else $error("untaken branch moved");

	mul_split_a: assert property (@(posedge clk) disable iff (!arst_n)
		(oneByte && opInfo.isMultiply)
		|=> ({result.mulHi, result.mulLo}
		== $past(regsIn.accA) * $past(regsIn.idxX)))
		else $error("multiply split wrong");

	br_taken_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.mode == AMD_REL && stFf.instr.branchTaken)
		|=> (result.nextPc == $past(stFf.regs.pc) + 16'h0002
		+ {{8{$past(fetchByte[7])}}, $past(fetchByte)}))
		else $error("taken branch target wrong");

	rm_mem_op_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.cls == AMD_CLS_REGMEM
		&& stFf.instr.mode != AMD_IMM && stFf.instr.mode != AMD_REL)
		|=> (result.opFromMem && result.eaValid))
		else $error("memory operand flag wrong");

	imm_no_addr_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(finish && stFf.instr.mode == AMD_IMM)
		|=> (!result.eaValid && !result.opFromMem))
		else $error("immediate marked as memory");

endmodule // amd_decoder

/* tb/amd_mem_model.sv */
// Program memory model feeding operand bytes
`timescale 1ns/100ps
module amd_mem_model
	import amd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic       fetchReady,
	output logic            fetchValid,
	output logic [7:0]      fetchByte
);
	logic [7:0] q[$];
	logic       took;
	logic       tog;

	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask

	initial
	begin
		fetchValid = 1'h0;
		fetchByte = 8'h00;
		tog = 1'h0;
		took = 1'h0;
	end

	always @(posedge clk)
		took = fetchValid && fetchReady;

	// Slow mode stalls every other cycle; idle bus shows toggling data
	always @(negedge clk)
	begin
		if (took)
			q.delete(0);
		tog = ~tog;
		fetchValid = (q.size() > 0) && !(slow && tog);
		fetchByte = fetchValid ? q[0] : ~fetchByte;
	end
endmodule // amd_mem_model

/* tb/testbench.sv */
// Self-checking testbench for the addressing mode decoder
`timescale 1ns/100ps
module testbench;
	import amd_pkg::*;
	logic        clk;
	logic        arst_n;
	logic        opValid;
	amd_instr_t  opInfo;
	amd_regs_t   regsIn;
	logic        fetchValid;
	logic [7:0]  fetchByte;
	logic        fetchReady;
	amd_result_t result;
	logic        slow;
	int          nFail;
	int          checkCount;

	amd_decoder amd_decoder_i (.clk(clk), .arst_n(arst_n),
		.opValid(opValid), .opInfo(opInfo), .regsIn(regsIn),
		.fetchValid(fetchValid), .fetchByte(fetchByte),
		.fetchReady(fetchReady), .result(result));
	amd_mem_model amd_mem_model_i (.clk(clk), .slow(slow),
		.fetchReady(fetchReady), .fetchValid(fetchValid),
		.fetchByte(fetchByte));

	always #10 clk = ~clk;

	task automatic summarize;
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			nFail++;
		end
	endtask

	// Issue the opcode, let the model serve bytes, wait for done;
	// done stands one cycle, so every edge from the opcode on is watched
	task automatic run(input int n, input logic [7:0] b0,
		input logic [7:0] b1);
		int   i;
		logic seen;
		if (n > 0)
			amd_mem_model_i.push(b0);
		if (n > 1)
			amd_mem_model_i.push(b1);
		@(negedge clk);
		opValid = 1'h1;
		seen = 1'h0;
		for (i = 0; i < 20 && !seen; i++)
		begin
			@(posedge clk);
			#1;
			seen = (result.done === 1'h1);
			@(negedge clk);
			opValid = 1'h0;
		end
		if (!seen)
		begin
			chk(seen, 1'h1);
			summarize;
		end
	endtask

	task automatic t_inh;
		opInfo = '{1'h1, AMD_INH, AMD_CLS_CTRL, 1'h0, 1'h0, 1'h0};
		run(0, 8'h00, 8'h00);
		chk(result.length, LEN_ONE);
		chk(result.eaValid, 1'h0);
		chk(result.mulValid, 1'h0);
		$display("test inherent done");
	endtask

	task automatic t_imm;
		opInfo = '{1'h1, AMD_IMM, AMD_CLS_REGMEM, 1'h1, 1'h0, 1'h0};
		run(1, 8'h5A, 8'h00);
		chk(result.length, LEN_TWO);
		chk(result.operand, 8'h5A);
		chk(result.opFromMem, 1'h0);
		chk(result.regSelX, 1'h1);
		$display("test immediate done");
	endtask

	task automatic t_dir;
		for (int k = 0; k < 5; k++)
		begin
			opInfo = '{1'h1, AMD_DIR, amd_class_t'(k), 1'h0, 1'h0, 1'h0};
			regsIn = '{8'h11, 8'h22, 16'h4000};
			run(1, 8'hFF, 8'h00);
			chk(result.effAddr, 16'h00FF);
			chk(result.length, LEN_TWO);
			chk(result.nextPc, 16'h4002);
		end
		chk(result.regSelX, 1'h0);
		$display("test direct done");
	endtask

	task automatic t_ext;
		slow = 1'h1;
		opInfo = '{1'h1, AMD_EXT, AMD_CLS_REGMEM, 1'h0, 1'h0, 1'h0};
		run(2, 8'h12, 8'h34);
		slow = 1'h0;
		chk(result.effAddr, 16'h1234);
		chk(result.length, LEN_THREE);
		chk(result.opFromMem, 1'h1);
		$display("test extended done");
	endtask

	task automatic t_idx;
		regsIn = '{8'h11, 8'hFF, 16'h2000};
		opInfo = '{1'h1, AMD_IX, AMD_CLS_REGMEM, 1'h1, 1'h0, 1'h0};
		run(0, 8'h00, 8'h00);
		chk(result.effAddr, 16'h00FF);
		chk(result.length, LEN_ONE);
		chk(result.regSelX, 1'h1);
		opInfo.mode = AMD_IX1;
		run(1, 8'hFF, 8'h00);
		chk(result.effAddr, 16'h01FE);
		chk(result.length, LEN_TWO);
		opInfo.mode = AMD_IX2;
		run(2, 8'hFF, 8'hF0);
		chk(result.effAddr, 16'h00EF);
		chk(result.length, LEN_THREE);
		run(2, 8'h01, 8'h02);
		chk(result.effAddr, 16'h0201);
		$display("test indexed done");
	endtask

	task automatic t_rel;
		logic [7:0]  off [3] = '{8'h80, 8'h7F, 8'h80};
		logic [15:0] exp [3] = '{16'h0F82, 16'h1081, 16'h1002};
		for (int k = 0; k < 3; k++)
		begin
			opInfo = '{1'h1, AMD_REL, AMD_CLS_JMPBR, 1'h0, 1'h0, k < 2};
			regsIn = '{8'h00, 8'h00, 16'h1000};
			run(1, off[k], 8'h00);
			chk(result.nextPc, exp[k]);
		end
		$display("test relative done");
	endtask

	task automatic t_mul;
		opInfo = '{1'h1, AMD_INH, AMD_CLS_REGMEM, 1'h0, 1'h1, 1'h0};
		regsIn = '{8'hFF, 8'hFF, 16'h0100};
		run(0, 8'h00, 8'h00);
		chk(result.mulValid, 1'h1);
		chk({result.mulHi, result.mulLo}, 16'hFE01);
		regsIn = '{8'h0D, 8'h20, 16'h0100};
		run(0, 8'h00, 8'h00);
		chk({result.mulHi, result.mulLo}, 16'h01A0);
		$display("test multiply done");
	endtask

	initial
	begin
		clk = 1'h0;
		arst_n = 1'h0;
		opValid = 1'h0;
		opInfo = '0;
		regsIn = '0;
		slow = 1'h0;
		nFail = 0;
		checkCount = 0;
		repeat (12) @(negedge clk);
		arst_n = 1'h1;
		chk(result, 64'h0);
		chk(fetchReady, 1'h0);
		t_inh;
		t_imm;
		t_dir;
		t_ext;
		t_idx;
		t_rel;
		t_mul;
		summarize;
	end
endmodule // testbench
